// ==== rtl/icc_core.sv ====
`default_nettype none
// Contract
// - Instruction cycle lasts exactly four clocks
// - Jump, call, return, table read: two cycles
// - Writing program counter low byte jumps, extra cycle
// - Taken skip costs one extra cycle
// - Skips test a byte or bit
// - Call saves return point after itself
// - Jump loads target, stack untouched
// - Bit set/clear keeps other bits
// - Logic operations update the zero flag
// - Rotates by one, carry variants through carry
// - Carry on sum overflow, borrow below zero
// - Increment/decrement by one, selectable target
// - Moves: memory/accumulator both ways, immediate
// - Logic combines memory with the accumulator
// - Table read moves program words to registers
// - Halt enters power-down state
// - Interrupt return sets global enable; return doesn't
module icc_core
    import icc_pkg::*;
#(
    parameter int              PC_W         = 11,          // Program counter width
    parameter int              STK_D        = 8,           // Return stack depth
    parameter logic [PC_W-1:0] RESET_VECTOR = '0,          // First fetch address
    parameter logic [7:0]      PCL_ADDR     = 8'h06        // Data address of the program counter low byte
) (
    input  wire logic                       i_clk,          // System clock
    input  wire logic                       i_sys_rst,      // Synchronous reset, active high
    output logic [PC_W-1:0]                 o_pmem_addr,    // Program memory address
    input  wire logic [INSTR_W-1:0]         i_pmem_data,    // Program memory word, read combinationally
    output logic [DATA_W-1:0]               o_dmem_addr,    // Data memory address
    input  wire logic [DATA_W-1:0]          i_dmem_rdata,   // Data memory byte, read combinationally
    output logic [DATA_W-1:0]               o_dmem_wdata,   // Data memory write byte
    output logic                            o_dmem_we,      // Data memory write strobe
    output logic [INSTR_W-DATA_W-1:0]       o_table_high,   // Upper part of the last table word
    output logic [DATA_W-1:0]               o_acc,          // Accumulator
    output logic                            o_zero_flag,    // Zero flag
    output logic                            o_carry_flag,   // Carry flag
    output logic                            o_global_interrupt_enable, // Global interrupt enable
    input  wire logic                       i_gie_clear,    // Clears the global enable (same clock) unless an interrupt return commits in that clock
    output logic                            o_power_down,   // Core is halted
    input  wire logic                       i_wake,         // Wake request pin, asynchronous
    output icc_pkg::icc_phase_e             o_phase         // Current phase of the cycle
);
    import icc_pkg::*;

    localparam int SP_W = $clog2(STK_D); // Stack pointer width
    localparam logic [PC_W-1:0] PC_STEP = {{(PC_W-1){1'b0}}, 1'b1}; // Fetch increment
    localparam logic [SP_W-1:0] SP_STEP = {{(SP_W-1){1'b0}}, 1'b1}; // Stack step

    // All core state
    typedef struct packed {
        icc_phase_e                     phase;     // Phase counter
        logic [PC_W-1:0]                pc;        // Fetch address
        logic [INSTR_W-1:0]             ir;        // Prefetched instruction
        logic                           ir_valid;  // Prefetched instruction may execute
        logic                           tbl_pend;  // Table access cycle pending
        logic [DATA_W-1:0]              tbl_m;     // Table destination address
        logic [DATA_W-1:0]              acc;       // Accumulator
        logic                           zf;        // Zero flag
        logic                           cf;        // Carry flag
        logic                           gie;       // Global interrupt enable
        logic                           halt;      // Power-down state
        logic [STK_D-1:0][PC_W-1:0]     stk;       // Return stack
        logic [SP_W-1:0]                sp;        // Next free stack slot
        logic                           wr_en;     // Data write strobe
        logic [DATA_W-1:0]              wr_addr;   // Data write address
        logic [DATA_W-1:0]              wr_data;   // Data write byte
        logic [INSTR_W-DATA_W-1:0]      tbl_hi;    // Table word upper part
        logic                           wake_meta; // Wake synchroniser, first stage
        logic                           wake_sync; // Wake synchroniser, second stage
    } icc_state_s;

    icc_state_s st_ff;   // Registered state
    icc_state_s nxt_st;  // Next state

    // Decoded fields of the instruction in execution
    icc_op_e            op;       // Opcode
    logic [DATA_W-1:0]  arg;      // Data address or immediate
    logic [IDX_W-1:0]   bit_idx;  // Bit index
    logic               to_mem;   // Result goes to data memory
    logic [PC_W-1:0]    target;   // Branch target
    logic [DATA_W-1:0]  rd;       // Memory operand
    icc_alu_e           alu_op;   // Datapath operation
    logic [DATA_W-1:0]  alu_b;    // Datapath operand
    logic [DATA_W-1:0]  alu_res;  // Datapath result
    logic               alu_c;    // Datapath carry out
    logic               alu_cu;   // Carry affected
    logic               alu_zu;   // Zero affected
    logic               wr_req;   // Result written to data memory
    logic               flag_en;  // Datapath flags are kept
    logic               flush;    // Discard the prefetched instruction

    assign op      = icc_op_e'(st_ff.ir[OP_LSB +: OP_W]);
    assign arg     = st_ff.ir[ARG_LSB +: DATA_W];
    assign bit_idx = st_ff.ir[IDX_LSB +: IDX_W];
    assign to_mem  = st_ff.ir[DST_POS];
    assign target  = st_ff.ir[PC_W-1:0];
    // The program counter low byte is seen at its data address
    assign rd      = (arg == PCL_ADDR) ? st_ff.pc[DATA_W-1:0] : i_dmem_rdata;

    // Datapath operation and operand for each opcode
    always_comb begin
        alu_op = ALU_PASS;
        alu_b  = rd;
        case (op)
            OP_MOV_A_X:                 alu_b  = arg;
            OP_ADD_M:                   alu_op = ALU_ADD;
            OP_ADC_M:                   alu_op = ALU_ADC;
            OP_SUB_M:                   alu_op = ALU_SUB;
            OP_SBC_M:                   alu_op = ALU_SBC;
            OP_AND_M:                   alu_op = ALU_AND;
            OP_OR_M:                    alu_op = ALU_OR;
            OP_XOR_M:                   alu_op = ALU_XOR;
            OP_ADD_X: begin
                alu_op = ALU_ADD;
                alu_b  = arg;
            end
            OP_SUB_X: begin
                alu_op = ALU_SUB;
                alu_b  = arg;
            end
            OP_AND_X: begin
                alu_op = ALU_AND;
                alu_b  = arg;
            end
            OP_OR_X: begin
                alu_op = ALU_OR;
                alu_b  = arg;
            end
            OP_XOR_X: begin
                alu_op = ALU_XOR;
                alu_b  = arg;
            end
            OP_COMPLEMENT:              alu_op = ALU_NOT;
            OP_INC, OP_SKIP_INC_Z:      alu_op = ALU_INC;
            OP_DEC, OP_SKIP_DEC_Z:      alu_op = ALU_DEC;
            OP_ROT_R:                   alu_op = ALU_ROR;
            OP_ROT_L:                   alu_op = ALU_ROL;
            OP_ROT_R_CY:                alu_op = ALU_RORC;
            OP_ROT_L_CY:                alu_op = ALU_ROLC;
            OP_BIT_CLR:                 alu_op = ALU_BCLR;
            OP_BIT_SET:                 alu_op = ALU_BSET;
            default:                    alu_op = ALU_PASS;
        endcase
    end

    // Shared datapath
    icc_alu #(
        .DW (DATA_W)
    ) u_alu (
        .i_op        (alu_op),
        .i_acc       (st_ff.acc),
        .i_opnd      (alu_b),
        .i_bit       (bit_idx),
        .i_carry     (st_ff.cf),
        .o_result    (alu_res),
        .o_carry     (alu_c),
        .o_carry_upd (alu_cu),
        .o_zero_upd  (alu_zu)
    );

    // Next-state logic: fetch, execute and commit at the last phase
    always_comb begin
        nxt_st           = st_ff;
        wr_req           = 1'b0;
        flag_en          = 1'b0;
        flush            = 1'b0;
        nxt_st.wake_meta = i_wake;
        nxt_st.wake_sync = st_ff.wake_meta;
        nxt_st.wr_en     = 1'b0;
        if (i_gie_clear) begin
            nxt_st.gie = 1'b0;
        end
        // Four phases per instruction cycle
        case (st_ff.phase)
            PH_0:    nxt_st.phase = PH_1;
            PH_1:    nxt_st.phase = PH_2;
            PH_2:    nxt_st.phase = PH_3;
            default: nxt_st.phase = PH_0;
        endcase
        if (st_ff.phase == PH_3) begin
            if (st_ff.halt) begin
                // Powered down: wait for a synchronised wake request
                if (st_ff.wake_sync) begin
                    nxt_st.halt = 1'b0;
                end
            end else if (st_ff.tbl_pend) begin
                // Second cycle of a table read: no fetch, no execution
                nxt_st.tbl_pend = 1'b0;
                nxt_st.wr_en    = 1'b1;
                nxt_st.wr_addr  = st_ff.tbl_m;
                nxt_st.wr_data  = i_pmem_data[DATA_W-1:0];
                nxt_st.tbl_hi   = i_pmem_data[INSTR_W-1:DATA_W];
            end else begin
                // Prefetch the next word
                nxt_st.ir       = i_pmem_data;
                nxt_st.pc       = st_ff.pc + PC_STEP;
                nxt_st.ir_valid = 1'b1;
                // Only a valid prefetched word executes
                if (st_ff.ir_valid) begin
                    case (op)
                        OP_MOV_A_M, OP_MOV_A_X: nxt_st.acc = alu_res;
                        OP_MOV_M_A: begin
                            wr_req = 1'b1;
                        end
                        OP_ADD_M, OP_ADC_M, OP_SUB_M, OP_SBC_M, OP_AND_M, OP_OR_M, OP_XOR_M,
                        OP_COMPLEMENT, OP_INC, OP_DEC, OP_ROT_R, OP_ROT_L, OP_ROT_R_CY, OP_ROT_L_CY: begin
                            flag_en = 1'b1;
                            wr_req  = to_mem;
                            if (!to_mem) begin
                                nxt_st.acc = alu_res;
                            end
                        end
                        OP_ADD_X, OP_SUB_X, OP_AND_X, OP_OR_X, OP_XOR_X: begin
                            flag_en    = 1'b1;
                            nxt_st.acc = alu_res;
                        end
                        OP_BIT_CLR, OP_BIT_SET: begin
                            wr_req = 1'b1;
                        end
                        OP_SKIP_Z: begin
                            flush = (rd == '0);
                            if (to_mem) begin
                                nxt_st.acc = rd;
                            end
                        end
                        OP_SKIP_BZ:  flush = !rd[bit_idx];
                        OP_SKIP_BNZ: flush = rd[bit_idx];
                        OP_SKIP_INC_Z, OP_SKIP_DEC_Z: begin
                            flush  = (alu_res == '0);
                            wr_req = to_mem;
                            if (!to_mem) begin
                                nxt_st.acc = alu_res;
                            end
                        end
                        OP_JUMP: begin
                            nxt_st.pc = target;
                            flush     = 1'b1;
                        end
                        OP_CALL: begin
                            nxt_st.stk[st_ff.sp] = st_ff.pc;
                            nxt_st.sp            = st_ff.sp + SP_STEP;
                            nxt_st.pc            = target;
                            flush                = 1'b1;
                        end
                        OP_RET, OP_RET_INT: begin
                            nxt_st.sp = st_ff.sp - SP_STEP;
                            nxt_st.pc = st_ff.stk[st_ff.sp - SP_STEP];
                            flush     = 1'b1;
                            if (op == OP_RET_INT) begin
                                nxt_st.gie = 1'b1;
                            end
                        end
                        OP_HALT: nxt_st.halt = 1'b1;
                        OP_TABLE_RD: begin
                            nxt_st.tbl_pend = 1'b1;
                            nxt_st.tbl_m    = arg;
                        end
                        default: flush = 1'b0;
                    endcase
                    // Flags from the datapath
                    if (flag_en && alu_zu) begin
                        nxt_st.zf = (alu_res == '0);
                    end
                    if (flag_en && alu_cu) begin
                        nxt_st.cf = alu_c;
                    end
                    // A write to the program counter low byte becomes a jump
                    if (wr_req) begin
                        if (arg == PCL_ADDR) begin
                            nxt_st.pc = {st_ff.pc[PC_W-1:DATA_W], (op == OP_MOV_M_A) ? st_ff.acc : alu_res};
                            flush     = 1'b1;
                        end else begin
                            nxt_st.wr_en   = 1'b1;
                            nxt_st.wr_addr = arg;
                            nxt_st.wr_data = (op == OP_MOV_M_A) ? st_ff.acc : alu_res;
                        end
                    end
                    // Skip or branch: the fetched word is dropped, costing one cycle
                    if (flush) begin
                        nxt_st.ir_valid = 1'b0;
                    end
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_ff       <= '0;
            st_ff.phase <= PH_0;
            st_ff.pc    <= RESET_VECTOR;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Table cycle addresses the page of the current fetch, low byte from the accumulator
    assign o_pmem_addr  = st_ff.tbl_pend ? {st_ff.pc[PC_W-1:DATA_W], st_ff.acc} : st_ff.pc;
    assign o_dmem_addr  = st_ff.wr_en ? st_ff.wr_addr : arg;
    assign o_dmem_wdata = st_ff.wr_data;
    assign o_dmem_we    = st_ff.wr_en;
    assign o_table_high = st_ff.tbl_hi;
    assign o_acc        = st_ff.acc;
    assign o_zero_flag  = st_ff.zf;
    assign o_carry_flag = st_ff.cf;
    assign o_global_interrupt_enable = st_ff.gie;
    assign o_power_down = st_ff.halt;
    assign o_phase      = st_ff.phase;
endmodule
`default_nettype wire

// ==== include/icc_pkg.sv ====
`default_nettype none
// Shared constants and types of the instruction-cycle core
package icc_pkg;
    localparam int DATA_W   = 8;   // Data byte width
    localparam int INSTR_W  = 17;  // Instruction word width
    localparam int OP_LSB   = 11;  // Opcode field position
    localparam int OP_W     = 6;   // Opcode field width
    localparam int DST_POS  = 10;  // Result target: 1 = data memory, 0 = accumulator
    localparam int IDX_LSB  = 8;   // Bit index field position
    localparam int IDX_W    = 3;   // Bit index field width
    localparam int ARG_LSB  = 0;   // Address or immediate field position
    localparam int PHASES   = 4;   // System clocks per instruction cycle

    // Phase of the instruction cycle, Gray coded
    typedef enum logic [1:0] {
        PH_0 = 2'h0,
        PH_1 = 2'h1,
        PH_2 = 2'h3,
        PH_3 = 2'h2
    } icc_phase_e;

    // Instruction opcodes
    typedef enum logic [OP_W-1:0] {
        OP_NOP        = 6'h00,
        OP_MOV_A_M    = 6'h01,
        OP_MOV_M_A    = 6'h02,
        OP_MOV_A_X    = 6'h03,
        OP_ADD_M      = 6'h04,
        OP_ADC_M      = 6'h05,
        OP_SUB_M      = 6'h06,
        OP_SBC_M      = 6'h07,
        OP_AND_M      = 6'h08,
        OP_OR_M       = 6'h09,
        OP_XOR_M      = 6'h0A,
        OP_ADD_X      = 6'h0B,
        OP_SUB_X      = 6'h0C,
        OP_AND_X      = 6'h0D,
        OP_OR_X       = 6'h0E,
        OP_XOR_X      = 6'h0F,
        OP_COMPLEMENT = 6'h10,
        OP_INC        = 6'h11,
        OP_DEC        = 6'h12,
        OP_ROT_R      = 6'h13,
        OP_ROT_L      = 6'h14,
        OP_ROT_R_CY   = 6'h15,
        OP_ROT_L_CY   = 6'h16,
        OP_BIT_CLR    = 6'h17,
        OP_BIT_SET    = 6'h18,
        OP_SKIP_Z     = 6'h19,
        OP_SKIP_BZ    = 6'h1A,
        OP_SKIP_BNZ   = 6'h1B,
        OP_SKIP_INC_Z = 6'h1C,
        OP_SKIP_DEC_Z = 6'h1D,
        OP_JUMP       = 6'h1E,
        OP_CALL       = 6'h1F,
        OP_RET        = 6'h20,
        OP_RET_INT    = 6'h21,
        OP_HALT       = 6'h22,
        OP_TABLE_RD   = 6'h23
    } icc_op_e;

    // Datapath operations
    typedef enum logic [4:0] {
        ALU_PASS, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR,
        ALU_NOT, ALU_INC, ALU_DEC, ALU_ROR, ALU_ROL, ALU_RORC, ALU_ROLC,
        ALU_BCLR, ALU_BSET
    } icc_alu_e;
endpackage
`default_nettype wire

// ==== rtl/icc_alu.sv ====
`default_nettype none
// Eight-bit datapath: arithmetic, logic, rotate and bit operations
module icc_alu
    import icc_pkg::*;
#(
    parameter int DW = DATA_W
) (
    input  wire icc_pkg::icc_alu_e i_op,       // Operation
    input  wire logic [DW-1:0]     i_acc,      // Accumulator operand
    input  wire logic [DW-1:0]     i_opnd,     // Memory or immediate operand
    input  wire logic [IDX_W-1:0]  i_bit,      // Bit index
    input  wire logic              i_carry,    // Carry flag in
    output logic [DW-1:0]          o_result,   // Result byte
    output logic                   o_carry,    // Carry or borrow out
    output logic                   o_carry_upd,// Carry flag is affected
    output logic                   o_zero_upd  // Zero flag is affected
);
    localparam logic [DW:0] ONE = {{DW{1'b0}}, 1'b1}; // Unit step

    logic [DW:0] sum; // Result with carry bit

    // Operation select
    always_comb begin
        sum         = '0;
        o_result    = i_opnd;
        o_carry     = i_carry;
        o_carry_upd = 1'b0;
        o_zero_upd  = 1'b0;
        case (i_op)
            ALU_ADD, ALU_ADC: begin
                sum = {1'b0, i_acc} + {1'b0, i_opnd} + ((i_op == ALU_ADC && i_carry) ? ONE : '0);
                o_result    = sum[DW-1:0];
                o_carry     = sum[DW];
                o_carry_upd = 1'b1;
                o_zero_upd  = 1'b1;
            end
            ALU_SUB, ALU_SBC: begin
                // Carry holds the borrow: set when the difference goes below zero
                sum = {1'b0, i_acc} - {1'b0, i_opnd} - ((i_op == ALU_SBC && i_carry) ? ONE : '0);
                o_result    = sum[DW-1:0];
                o_carry     = sum[DW];
                o_carry_upd = 1'b1;
                o_zero_upd  = 1'b1;
            end
            ALU_AND: begin
                o_result   = i_acc & i_opnd;
                o_zero_upd = 1'b1;
            end
            ALU_OR: begin
                o_result   = i_acc | i_opnd;
                o_zero_upd = 1'b1;
            end
            ALU_XOR: begin
                o_result   = i_acc ^ i_opnd;
                o_zero_upd = 1'b1;
            end
            ALU_NOT: begin
                o_result   = ~i_opnd;
                o_zero_upd = 1'b1;
            end
            ALU_INC: begin
                sum        = {1'b0, i_opnd} + ONE;
                o_result   = sum[DW-1:0];
                o_zero_upd = 1'b1;
            end
            ALU_DEC: begin
                sum        = {1'b0, i_opnd} - ONE;
                o_result   = sum[DW-1:0];
                o_zero_upd = 1'b1;
            end
            ALU_ROR:  o_result = {i_opnd[0], i_opnd[DW-1:1]};
            ALU_ROL:  o_result = {i_opnd[DW-2:0], i_opnd[DW-1]};
            ALU_RORC: begin
                o_result    = {i_carry, i_opnd[DW-1:1]};
                o_carry     = i_opnd[0];
                o_carry_upd = 1'b1;
            end
            ALU_ROLC: begin
                o_result    = {i_opnd[DW-2:0], i_carry};
                o_carry     = i_opnd[DW-1];
                o_carry_upd = 1'b1;
            end
            ALU_BCLR: o_result[i_bit] = 1'b0;
            ALU_BSET: o_result[i_bit] = 1'b1;
            default:  o_result = i_opnd;
        endcase
    end
endmodule
`default_nettype wire

// ==== bench/icc_core_monitor.sv ====
`default_nettype none
// Port-level checks of cycle framing and commit timing
module icc_core_monitor
    import icc_pkg::*;
#(
    parameter int         PC_W     = 11,   // Program counter width
    parameter logic [7:0] PCL_ADDR = 8'h06 // Program counter low byte address
) (
    input wire logic              i_clk,
    input wire logic              i_sys_rst,
    input wire logic [PC_W-1:0]   o_pmem_addr,
    input wire logic [DATA_W-1:0] o_dmem_addr,
    input wire logic              o_dmem_we,
    input wire logic [DATA_W-1:0] o_acc,
    input wire logic              o_zero_flag,
    input wire logic              o_carry_flag,
    input wire logic              o_global_interrupt_enable,
    input wire logic              o_power_down,
    input wire icc_phase_e        o_phase
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_phase_order: assert property (o_phase == PH_0 |=> o_phase == PH_1 ##1 o_phase == PH_2
        ##1 o_phase == PH_3 ##1 o_phase == PH_0) else $error("phase sequence broken");
    a_reset_state: assert property (disable iff (1'b0) i_sys_rst |=>
        o_phase == PH_0 && o_acc == 8'h00 && !o_power_down) else $error("reset state wrong");
    a_write_pulse: assert property (o_dmem_we |-> o_phase == PH_0 ##1 !o_dmem_we)
        else $error("write strobe not a single first-phase pulse");
    a_fetch_stable: assert property (o_phase != PH_0 |-> $stable(o_pmem_addr))
        else $error("fetch address moved inside a cycle");
    a_pcl_no_write: assert property (o_dmem_we |-> o_dmem_addr != PCL_ADDR)
        else $error("program counter low byte written to memory");
    a_gie_rise: assert property ($rose(o_global_interrupt_enable) |-> o_phase == PH_0)
        else $error("global enable set off a cycle boundary");
    a_commit_edge: assert property (o_phase != PH_0 |-> $stable({o_acc, o_zero_flag, o_carry_flag}))
        else $error("result changed inside a cycle");
    a_halt_entry: assert property ($rose(o_power_down) |-> o_phase == PH_0 && $past(o_phase) == PH_3)
        else $error("halt entered off a cycle boundary");
endmodule
bind icc_core icc_core_monitor #(.PC_W(PC_W), .PCL_ADDR(PCL_ADDR)) icc_core_monitor_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_pmem_addr(o_pmem_addr), .o_dmem_addr(o_dmem_addr),
    .o_dmem_we(o_dmem_we), .o_acc(o_acc), .o_zero_flag(o_zero_flag), .o_carry_flag(o_carry_flag),
    .o_global_interrupt_enable(o_global_interrupt_enable), .o_power_down(o_power_down), .o_phase(o_phase));
`default_nettype wire

// ==== bench/icc_core_tb.sv ====
`default_nettype none
// Runs short programs, compares timing and results with a bench model
module icc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import icc_pkg::*;
    logic        i_clk = 0, i_sys_rst = 1, i_gie_clear = 0, i_wake = 0;
    logic        o_dmem_we, o_zero_flag, o_carry_flag, o_global_interrupt_enable, o_power_down;
    logic [10:0] o_pmem_addr;
    logic [7:0]  o_dmem_addr, o_dmem_wdata, o_acc, a, b;
    logic [8:0]  o_table_high;
    logic [16:0] pmem [2048];
    logic [7:0]  dmem [256];
    logic [31:0] lfsr = 32'h56db_c2ac;
    icc_phase_e  o_phase;
    int          fail_count = 0, n_checks = 0, cyc = 0, n, s, t;
    icc_op_e     ops [15] = '{OP_ADD_M, OP_ADC_M, OP_SUB_M, OP_SBC_M, OP_AND_M, OP_OR_M, OP_XOR_M,
                              OP_COMPLEMENT, OP_INC, OP_DEC, OP_ROT_L_CY, OP_ROT_R_CY,
                              OP_ROT_L, OP_ROT_R, OP_MOV_A_M};
    icc_core icc_core_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_pmem_addr(o_pmem_addr),
        .i_pmem_data(pmem[o_pmem_addr]), .o_dmem_addr(o_dmem_addr), .i_dmem_rdata(dmem[o_dmem_addr]),
        .o_dmem_wdata(o_dmem_wdata), .o_dmem_we(o_dmem_we), .o_table_high(o_table_high), .o_acc(o_acc),
        .o_zero_flag(o_zero_flag), .o_carry_flag(o_carry_flag), .i_gie_clear(i_gie_clear),
        .o_global_interrupt_enable(o_global_interrupt_enable), .o_power_down(o_power_down),
        .i_wake(i_wake), .o_phase(o_phase));
    always #4 i_clk = ~i_clk;
    // Data memory model and hang limit
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_dmem_we === 1'b1) dmem[o_dmem_addr] <= o_dmem_wdata;
        if (cyc == 4000) begin
            fail_count++;
            print_verdict();
        end
    end
    // Next pseudo-random value
    function void step;
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    endfunction
    // Compare and count
    task chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Place one program word
    task ld(int ad, icc_op_e op, logic [10:0] f);
        pmem[ad] <= {op, f};
    endtask
    // Reset, then count clocks until the program halts
    task run(int clocks);
        @(posedge i_clk) i_sys_rst <= 1;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 0;
        n = 0;
        while (o_power_down !== 1'b1 && n < 300) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("clocks", n, clocks);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        foreach (pmem[i]) pmem[i] = '0;
        foreach (dmem[i]) dmem[i] = '0;
        // Every datapath operation except bit clear and bit set, result target alternating
        foreach (ops[k]) begin
            step();
            a = (k < 2) ? 8'hFF : lfsr[7:0];
            b = (k < 2) ? 8'h01 : lfsr[15:8];
            t = k % 2;
            dmem[64] <= b;
            ld(0, OP_MOV_A_X, {3'h0, a});
            ld(1, ops[k], {t[0], 10'h040});
            ld(2, OP_HALT, '0);
            run(16);
            case (ops[k])
                OP_ADD_M, OP_ADC_M: s = a + b;
                OP_SUB_M, OP_SBC_M: s = a - b;
                OP_AND_M:      s = a & b;
                OP_OR_M:       s = a | b;
                OP_XOR_M:      s = a ^ b;
                OP_COMPLEMENT: s = 255 - b;
                OP_INC:        s = b + 1;
                OP_DEC:        s = b - 1;
                OP_ROT_L_CY:   s = b * 2;
                OP_ROT_L:      s = b * 2 % 256 + b / 128;
                OP_ROT_R:      s = b / 2 + 128 * (b % 2);
                OP_MOV_A_M:    s = b;
                default:       s = b / 2 + 256 * (b % 2);
            endcase
            chk("acc", o_acc, t ? a : s[7:0]);
            chk("mem", dmem[64], t ? s[7:0] : b);
            chk("carry", o_carry_flag, (k < 4 || k > 9) && (s > 255 || s < 0));
            chk("zero", o_zero_flag, k < 10 && s[7:0] == 0);
        end
        // Call, return, jump, taken skips, low byte write, bit set
        b = lfsr[23:16] & 8'hF7;
        dmem[65] <= 8'h00;
        dmem[66] <= b;
        ld(0, OP_CALL, 11'h005);
        ld(1, OP_JUMP, 11'h008);
        ld(5, OP_MOV_A_X, 11'h03C);
        ld(6, OP_RET, '0);
        ld(8, OP_SKIP_Z, 11'h041);
        ld(9, OP_MOV_A_X, 11'h0FF);
        ld(10, OP_MOV_M_A, 11'h006);
        ld(60, OP_BIT_SET, 11'h342);
        ld(61, OP_SKIP_BNZ, 11'h342);
        ld(62, OP_MOV_A_X, 11'h0FF);
        ld(63, OP_SKIP_BZ, 11'h342);
        ld(64, OP_HALT, '0);
        run(68);
        chk("acc", o_acc, 8'h3C);
        chk("bit", dmem[66], b | 8'h08);
        chk("gie", o_global_interrupt_enable, 0);
        // Table read, interrupt return, enable clear, wake
        step();
        pmem[32] <= lfsr[16:0];
        ld(0, OP_MOV_A_X, 11'h020);
        ld(1, OP_TABLE_RD, 11'h043);
        ld(2, OP_CALL, 11'h004);
        ld(3, OP_HALT, '0);
        ld(4, OP_RET_INT, '0);
        run(36);
        chk("tbl_low", dmem[67], lfsr[7:0]);
        chk("tbl_high", o_table_high, lfsr[16:8]);
        chk("gie", o_global_interrupt_enable, 1);
        @(posedge i_clk) i_gie_clear <= 1;
        @(posedge i_clk);
        i_gie_clear <= 0;
        i_wake <= 1;
        n = 0;
        while (o_power_down !== 1'b0 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("gie", o_global_interrupt_enable, 0);
        chk("halt", o_power_down, 0);
        i_wake <= 0;
        print_verdict();
    end
endmodule
`default_nettype wire
